// >>> i2sf_pkg.sv
// Constants for the I2C status flag block
// Overview of operation
// [R1] Status bit 15 shows last acknowledge level
// [R2] Acknowledge bit updates only at acknowledge end
// [R3] Transmit bit high through eight bits plus acknowledge
// [R4] Set at transmit start, clear after acknowledge
// [R5] Status bits 13 to 11 read zero
// [R6] Collision flag bit 10, software clears with zero
// [R7] Set collision flag on master bus collision
// [R8] Transmit write while busy sets write collision
// [R9] Byte arriving on full buffer sets overflow
// [R10] Status reads have no side effect
`default_nettype none
package i2sf_pkg;
   localparam int          ADDR_W        = 3;
   localparam int          DATA_W        = 16;
   localparam int          BYTE_W        = 8;
   localparam int          IRQ_W         = 5;
   localparam int          CNT_W         = 4;
   // Register offsets
   localparam logic [2:0]  OFF_STATUS    = 3'h0;
   localparam logic [2:0]  OFF_CTRL      = 3'h1;
   localparam logic [2:0]  OFF_TX_BUF    = 3'h2;
   localparam logic [2:0]  OFF_RX_BUF    = 3'h3;
   localparam logic [2:0]  OFF_IRQ_STAT  = 3'h4;
   localparam logic [2:0]  OFF_IRQ_MASK  = 3'h5;
   // Status word fields
   localparam int          ST_ACK        = 15;
   localparam int          ST_TX         = 14;
   localparam int          ST_BCL        = 10;
   localparam int          ST_WCOL       = 7;
   localparam int          ST_OVF        = 6;
   localparam int          ST_RBF        = 1;
   localparam int          ST_TBF        = 0;
   localparam logic [15:0] STATUS_RESET  = 16'h0000;
   // Control fields
   localparam int          CT_RX_EN      = 0;
   // Interrupt bits
   localparam int          IRQ_TX_DONE   = 0;
   localparam int          IRQ_COLL      = 1;
   localparam int          IRQ_WCOL      = 2;
   localparam int          IRQ_OVF       = 3;
   localparam int          IRQ_RX_RDY    = 4;
   // Bit index of the acknowledge slot
   localparam logic [3:0]  ACK_SLOT      = 4'h8;
   localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
   typedef enum logic [1:0] {MODE_IDLE, MODE_TX, MODE_RX} i2sf_mode_t;
endpackage : i2sf_pkg
`default_nettype wire

// >>> i2sf_sync.sv
// Two-flop synchroniser with edge detection
`default_nettype none
module i2sf_sync
(
   input  wire logic sys_clk,  // System clock
   input  wire logic nrst,     // Sync reset, active low
   input  wire logic async_in, // Pin from outside domain
   output logic      level,    // Synchronised level
   output logic      rise,     // One-cycle rising pulse
   output logic      fall      // One-cycle falling pulse
);
   logic [2:0] sh_q;
   logic [2:0] sh_d;

   always_comb
   begin
      sh_d = {sh_q[1:0], async_in};
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         sh_q <= 3'h7;
      else
         sh_q <= sh_d;
   end

   // Only stages 1 and 2 feed logic
   assign level = sh_q[1];
   assign rise  = sh_q[1] & ~sh_q[2];
   assign fall  = ~sh_q[1] & sh_q[2];
endmodule : i2sf_sync
`default_nettype wire

// >>> i2sf_status.sv
// I2C status flags with byte shifter and register port
`default_nettype none
module i2sf_status
   import i2sf_pkg::*;
(
   input  wire logic              sys_clk, // 10 MHz clock
   input  wire logic              nrst,    // Sync reset, active low
   input  wire logic [ADDR_W-1:0] addr,    // Register address
   input  wire logic [DATA_W-1:0] wdata,   // Write data
   input  wire logic              wr,      // Write strobe
   input  wire logic              rd,      // Read strobe
   output logic      [DATA_W-1:0] rdata,   // Read data, next cycle
   input  wire logic              scl_in,  // Bus clock pin
   input  wire logic              sda_in,  // Bus data pin
   output logic                   sda_out, // Data drive level
   output logic                   sda_oe,  // Data pulled low
   output logic                   irq      // Level interrupt
);
   logic scl_rise;
   logic scl_fall;
   logic sda_lvl;

   i2sf_sync u_scl_sync
   (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .async_in (scl_in),
      .level    (),
      .rise     (scl_rise),
      .fall     (scl_fall)
   );

   i2sf_sync u_sda_sync
   (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .async_in (sda_in),
      .level    (sda_lvl),
      .rise     (),
      .fall     ()
   );

   i2sf_mode_t        mode_q,      mode_d;
   logic [CNT_W-1:0]  cnt_q,       cnt_d;
   logic [BYTE_W-1:0] shift_q,     shift_d;
   logic [BYTE_W-1:0] tx_buf_q,    tx_buf_d;
   logic [BYTE_W-1:0] rx_buf_q,    rx_buf_d;
   logic              ack_samp_q,  ack_samp_d;
   logic              ack_q,       ack_d;
   logic              bcl_q,       bcl_d;
   logic              wcol_q,      wcol_d;
   logic              ovf_q,       ovf_d;
   logic              rbf_q,       rbf_d;
   logic              rx_en_q,     rx_en_d;
   logic              oe_q,        oe_d;
   logic [IRQ_W-1:0]  irq_stat_q,  irq_stat_d;
   logic [IRQ_W-1:0]  irq_mask_q,  irq_mask_d;
   logic [DATA_W-1:0] rdata_q,     rdata_d;
   logic [DATA_W-1:0] status_w;
   logic [IRQ_W-1:0]  ev;
   logic              wr_st;
   logic              wr_tx;
   logic              tx_ok;
   logic              ev_coll;
   logic              ev_done;
   logic              ev_wcol;
   logic              ev_ovf;
   logic              ev_rdy;
   logic              ack_close;

   assign wr_st = wr && (addr == OFF_STATUS);
   assign wr_tx = wr && (addr == OFF_TX_BUF);
   assign tx_ok = wr_tx && (mode_q == MODE_IDLE);
   assign ack_close = (mode_q == MODE_TX) && (cnt_q == ACK_SLOT) && scl_fall;

   always_comb
   begin
      status_w          = STATUS_RESET;          // R5
      status_w[ST_ACK]  = ack_q;                 // R1
      status_w[ST_TX]   = (mode_q == MODE_TX);   // R3
      status_w[ST_BCL]  = bcl_q;
      status_w[ST_WCOL] = wcol_q;
      status_w[ST_OVF]  = ovf_q;
      status_w[ST_RBF]  = rbf_q;
      status_w[ST_TBF]  = (mode_q == MODE_TX);
   end

   // Byte engine
   always_comb
   begin
      mode_d     = mode_q;
      cnt_d      = cnt_q;
      shift_d    = shift_q;
      ack_samp_d = ack_samp_q;
      ack_d      = ack_q;
      rx_buf_d   = rx_buf_q;
      ev_coll    = 1'b0;
      ev_done    = 1'b0;
      ev_ovf     = 1'b0;
      ev_rdy     = 1'b0;
      case (mode_q)
         MODE_IDLE:
         begin
            cnt_d = '0;
            if (tx_ok)
            begin
               mode_d  = MODE_TX;                 // R4
               shift_d = wdata[BYTE_W-1:0];
            end
            else if (rx_en_q)
               mode_d = MODE_RX;
         end
         MODE_TX:
         begin
            if (scl_rise)
            begin
               if (cnt_q == ACK_SLOT)
                  ack_samp_d = sda_lvl;
               else if (shift_q[BYTE_W-1] && !sda_lvl)
               begin
                  ev_coll = 1'b1;                 // R7
                  mode_d  = MODE_IDLE;
               end
            end
            else if (scl_fall)
            begin
               if (cnt_q == ACK_SLOT)
               begin
                  ack_d   = ack_samp_q;           // R2
                  mode_d  = MODE_IDLE;            // R4
                  ev_done = 1'b1;
               end
               else
               begin
                  cnt_d   = cnt_q + 4'h1;         // R3
                  shift_d = {shift_q[BYTE_W-2:0], 1'b0};
               end
            end
         end
         MODE_RX:
         begin
            if (scl_rise)
            begin
               if (cnt_q == ACK_SLOT)
               begin
                  cnt_d = '0;
                  if (!rx_en_q)
                     mode_d = MODE_IDLE;
               end
               else
               begin
                  cnt_d   = cnt_q + 4'h1;
                  shift_d = {shift_q[BYTE_W-2:0], sda_lvl};
                  if (cnt_q == LAST_DATA_BIT)
                  begin
                     if (rbf_q)
                        ev_ovf = 1'b1;            // R9
                     else
                     begin
                        rx_buf_d = {shift_q[BYTE_W-2:0], sda_lvl};
                        ev_rdy   = 1'b1;
                     end
                  end
               end
            end
            else if (!rx_en_q && cnt_q == '0)
               mode_d = MODE_IDLE;
         end
         default:
         begin
            mode_d = MODE_IDLE;
         end
      endcase
      oe_d = (mode_d == MODE_TX) && (cnt_d < ACK_SLOT)
             && !shift_d[BYTE_W-1];
   end

   assign ev_wcol = wr_tx && (mode_q != MODE_IDLE);  // R8

   // Register file, hardware set wins over clear
   always_comb
   begin
      tx_buf_d   = tx_ok ? wdata[BYTE_W-1:0] : tx_buf_q;
      rx_en_d    = rx_en_q;
      irq_mask_d = irq_mask_q;
      bcl_d      = bcl_q;
      wcol_d     = wcol_q;
      ovf_d      = ovf_q;
      rbf_d      = rbf_q;
      irq_stat_d = irq_stat_q;
      rdata_d    = '0;
      if (wr && addr == OFF_CTRL)
         rx_en_d = wdata[CT_RX_EN];
      if (wr && addr == OFF_IRQ_MASK)
         irq_mask_d = wdata[IRQ_W-1:0];
      if (wr && addr == OFF_IRQ_STAT)
         irq_stat_d = irq_stat_q & ~wdata[IRQ_W-1:0];
      if (wr_st)
      begin
         bcl_d  = bcl_q & wdata[ST_BCL];          // R6
         wcol_d = wcol_q & wdata[ST_WCOL];        // R8
         ovf_d  = ovf_q & wdata[ST_OVF];          // R9
      end
      if (rd && addr == OFF_RX_BUF)
         rbf_d = 1'b0;
      bcl_d      = bcl_d | ev_coll;               // R7
      wcol_d     = wcol_d | ev_wcol;              // R8
      ovf_d      = ovf_d | ev_ovf;                // R9
      rbf_d      = rbf_d | ev_rdy;
      irq_stat_d = irq_stat_d | ev;
      if (rd)
      begin
         case (addr)
            OFF_STATUS:   rdata_d = status_w;     // R10
            OFF_CTRL:     rdata_d[CT_RX_EN] = rx_en_q;
            OFF_TX_BUF:   rdata_d[BYTE_W-1:0] = tx_buf_q;
            OFF_RX_BUF:   rdata_d[BYTE_W-1:0] = rx_buf_q;
            OFF_IRQ_STAT: rdata_d[IRQ_W-1:0] = irq_stat_q;
            OFF_IRQ_MASK: rdata_d[IRQ_W-1:0] = irq_mask_q;
            default:      rdata_d = '0;
         endcase
      end
   end

   always_comb
   begin
      ev              = '0;
      ev[IRQ_TX_DONE] = ev_done;
      ev[IRQ_COLL]    = ev_coll;
      ev[IRQ_WCOL]    = ev_wcol;
      ev[IRQ_OVF]     = ev_ovf;
      ev[IRQ_RX_RDY]  = ev_rdy;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         mode_q     <= MODE_IDLE;
         cnt_q      <= '0;
         shift_q    <= '0;
         tx_buf_q   <= '0;
         rx_buf_q   <= '0;
         ack_samp_q <= 1'b0;
         ack_q      <= 1'b0;
         bcl_q      <= 1'b0;
         wcol_q     <= 1'b0;
         ovf_q      <= 1'b0;
         rbf_q      <= 1'b0;
         rx_en_q    <= 1'b0;
         oe_q       <= 1'b0;
         irq_stat_q <= '0;
         irq_mask_q <= '0;
         rdata_q    <= '0;
      end
      else
      begin
         mode_q     <= mode_d;
         cnt_q      <= cnt_d;
         shift_q    <= shift_d;
         tx_buf_q   <= tx_buf_d;
         rx_buf_q   <= rx_buf_d;
         ack_samp_q <= ack_samp_d;
         ack_q      <= ack_d;
         bcl_q      <= bcl_d;
         wcol_q     <= wcol_d;
         ovf_q      <= ovf_d;
         rbf_q      <= rbf_d;
         rx_en_q    <= rx_en_d;
         oe_q       <= oe_d;
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= irq_mask_d;
         rdata_q    <= rdata_d;
      end
   end

   assign rdata   = rdata_q;
   assign sda_out = 1'b0;
   assign sda_oe  = oe_q;
   assign irq     = |(irq_stat_q & irq_mask_q);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_ack_close;
      ack_close;
   endsequence

   sequence s_st_read;
      rd && addr == OFF_STATUS;
   endsequence

   chk_unimpl_zero: assert property // R5
      (s_st_read |=> rdata[13:11] == 3'h0)
      else $error("unimplemented status bits not zero");
   chk_ack_update: assert property // R2
      ($changed(ack_q) |-> $past(ack_close))
      else $error("ack status changed outside ack close");
   chk_ack_value: assert property // R1
      (s_ack_close |=> ack_q == $past(ack_samp_q) && mode_q == MODE_IDLE)
      else $error("ack status not the sampled level");
   chk_tx_start: assert property // R4
      (tx_ok |=> mode_q == MODE_TX && status_w[ST_TX] && cnt_q == 4'h0)
      else $error("transmit did not start");
   chk_tx_clear: assert property // R3
      ($fell(status_w[ST_TX]) |-> $past(ack_close) || $past(ev_coll))
      else $error("transmit bit cleared early");
   chk_bcl_set: assert property // R7
      (ev_coll |=> bcl_q && !oe_q && mode_q == MODE_IDLE)
      else $error("collision not flagged");
   chk_bcl_clear: assert property // R6
      (wr_st && !wdata[ST_BCL] && !ev_coll |=> !bcl_q)
      else $error("collision flag not cleared");
   chk_wcol_set: assert property // R8
      (ev_wcol |=> wcol_q && $stable(tx_buf_q))
      else $error("write collision not flagged");
   chk_ovf_set: assert property // R9
      (ev_ovf |=> ovf_q && $stable(rx_buf_q))
      else $error("overflow not flagged");
   chk_read_quiet: assert property // R10
      ((s_st_read ##0 (!wr && !ev_coll && !ev_ovf))
      |=> $stable({bcl_q, wcol_q, ovf_q}))
      else $error("status read changed flags");
endmodule : i2sf_status
`default_nettype wire

// >>> i2sf_bus_model.sv
// Far-side bus model: clock source and target that acks or pulls data
`default_nettype none
module i2sf_bus_model
(
   input  wire logic sda_oe, // Device pulls data low
   output logic      scl,    // Bus clock to device
   output logic      sda     // Resolved data wire
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       pull;
   logic [8:0] seen;
   // Pull-up: released wire reads one
   assign sda = !(sda_oe || pull);
   initial
   begin
      scl = 1'b1;
      pull = 1'b0;
      seen = '0;
   end
   // Data falls while clock high, then clock parks low
   task automatic start_bus();
      pull = 1'b1;
      #400 scl = 1'b0;
      #400 pull = 1'b0;
   endtask : start_bus
   // Nine clocks; a set bit of drv pulls data low in that slot
   task automatic frame(input logic [8:0] drv);
      for (int i = 8; i >= 0; i--)
      begin
         pull = drv[i];
         #400 scl = 1'b1;
         #200 seen[i] = sda;
         #200 scl = 1'b0;
      end
      pull = 1'b0;
   endtask : frame
endmodule : i2sf_bus_model
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the status flag block
`default_nettype none
module tb
   import i2sf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed
   {
      logic [7:0]  data;
      logic        nack;
      logic [15:0] st;
   } i2sf_row_t;
   i2sf_row_t         rows [4] = '{'{8'hA5, 1'b0, 16'h0000},
                                   '{8'h3C, 1'b1, 16'h8000},
                                   '{8'h00, 1'b0, 16'h0000},
                                   '{8'hFF, 1'b1, 16'h8000}};
   logic              sys_clk = 1'b0;
   logic              nrst = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic              scl;
   logic              sda;
   logic              sda_out;
   logic              sda_oe;
   logic              irq;
   logic              exp_ack = 1'b0;
   int                n_errors = 0;
   int                n_checks = 0;

   always #50 sys_clk = ~sys_clk;

   i2sf_status dut (.sys_clk(sys_clk), .nrst(nrst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
   i2sf_bus_model bm (.sda_oe(sda_oe), .scl(scl), .sda(sda));

   task automatic check(input string what, input logic [15:0] exp, got);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg

   task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp,
                         input string what);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 check(what, exp, rdata);
   endtask : rd_chk

   task automatic print_verdict();
      $display("Checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict

   initial
   begin
      #300000;
      n_errors++;
      print_verdict();
   end

   initial
   begin
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      rd_chk(OFF_STATUS, STATUS_RESET, "status reset");
      rd_chk(OFF_IRQ_STAT, 16'h0000, "irq stat reset");
      check("sda drive level", 16'h0000, {15'h0000, sda_out});
      check("sda released", 16'h0000, {15'h0000, sda_oe});
      wr_reg(OFF_IRQ_MASK, 16'h001F);
      bm.start_bus();
      foreach (rows[i])
      begin
         wr_reg(OFF_TX_BUF, {8'h00, rows[i].data});
         rd_chk(OFF_STATUS, {exp_ack, 15'h4001}, "status busy");
         bm.frame({8'h00, !rows[i].nack});
         repeat (6) @(posedge sys_clk);
         check("byte on wire", {8'h00, rows[i].data}, {8'h00, bm.seen[8:1]});
         rd_chk(OFF_STATUS, rows[i].st, "status done");
         check("irq done", 16'h0001, {15'h0000, irq});
         wr_reg(OFF_IRQ_STAT, 16'h0001);
         check("irq cleared", 16'h0000, {15'h0000, irq});
         exp_ack = rows[i].nack;
      end
      // Write while busy, then lose arbitration on the second bit
      wr_reg(OFF_TX_BUF, 16'h00FF);
      wr_reg(OFF_TX_BUF, 16'h0012);
      rd_chk(OFF_STATUS, 16'hC081, "status wcol");
      check("irq wcol", 16'h0001, {15'h0000, irq});
      bm.frame(9'h080);
      repeat (6) @(posedge sys_clk);
      rd_chk(OFF_STATUS, 16'h8480, "status bcl");
      rd_chk(OFF_STATUS, 16'h8480, "status reread");
      wr_reg(OFF_STATUS, 16'hFFFF);
      rd_chk(OFF_STATUS, 16'h8480, "status keep");
      wr_reg(OFF_STATUS, 16'hFB7F);
      rd_chk(OFF_STATUS, 16'h8000, "status clear");
      rd_chk(OFF_IRQ_STAT, 16'h0006, "irq stat coll");
      wr_reg(OFF_IRQ_MASK, 16'h0000);
      check("irq masked", 16'h0000, {15'h0000, irq});
      wr_reg(OFF_IRQ_STAT, 16'h0006);
      wr_reg(OFF_IRQ_MASK, 16'h001F);
      // Two received bytes without draining the first
      wr_reg(OFF_CTRL, 16'h0001);
      bm.frame({8'hA5, 1'b0});
      bm.frame({8'h3C, 1'b0});
      repeat (6) @(posedge sys_clk);
      rd_chk(OFF_STATUS, 16'h8042, "status ovf");
      rd_chk(OFF_RX_BUF, 16'h005A, "rx kept");
      rd_chk(OFF_STATUS, 16'h8040, "status drained");
      rd_chk(OFF_IRQ_STAT, 16'h0018, "irq stat rx");
      wr_reg(OFF_STATUS, 16'hFFBF);
      rd_chk(OFF_STATUS, 16'h8000, "ovf cleared");
      wr_reg(OFF_CTRL, 16'h0000);
      wr_reg(3'h7, 16'hFFFF);
      rd_chk(3'h6, 16'h0000, "unmapped");
      rd_chk(OFF_STATUS, 16'h8000, "status final");
      print_verdict();
   end
endmodule : tb
`default_nettype wire
